// [rtl/las_pkg.sv]
// las_pkg: register map, bit positions and reset values of the link alarm status bank.
// assumes a 32-bit AHB-Lite slave; printed offsets are word indices (byte address = 4 * index).
package las_pkg;

	localparam int NCH = 4;
	localparam int IDX_W = 20;
	localparam int DW = 8;

	// channel order: ac, ad, bc, bd
	localparam logic [IDX_W-1:0] TX_ST_IDX [NCH] = '{20'h30828, 20'h30838, 20'h30928, 20'h30938};
	localparam logic [IDX_W-1:0] RX_ST_IDX [NCH] = '{20'h30829, 20'h30839, 20'h30929, 20'h30939};
	localparam logic [IDX_W-1:0] TX_SH_IDX [NCH] = '{20'h3082a, 20'h3083a, 20'h3092a, 20'h3093a};
	localparam logic [IDX_W-1:0] RX_SH_IDX [NCH] = '{20'h3082b, 20'h3083b, 20'h3092b, 20'h3093b};
	localparam logic [IDX_W-1:0] TX_EN_IDX [NCH] = '{20'h30a40, 20'h30a42, 20'h30a44, 20'h30a46};
	localparam logic [IDX_W-1:0] RX_EN_IDX [NCH] = '{20'h30a41, 20'h30a43, 20'h30a45, 20'h30a47};
	localparam logic [IDX_W-1:0] CTRL_IDX = 20'h30a50;

	// transmit status bits
	localparam int TX_SOC_BIT  = 5;
	localparam int TX_URUN_BIT = 6;
	localparam int TX_ORUN_BIT = 7;

	// receive status bits
	localparam int RX_OOF_BIT   = 1;
	localparam int RX_EXSEQ_BIT = 2;
	localparam int RX_SEQ_BIT   = 3;
	localparam int RX_BIP_BIT   = 4;
	localparam int RX_B1_BIT    = 5;
	localparam int RX_OVR_BIT   = 6;
	localparam int RX_RDI_BIT   = 7;

	localparam logic [DW-1:0] TX_VALID_MASK = 8'he0;
	localparam logic [DW-1:0] RX_VALID_MASK = 8'hfe;
	localparam logic [DW-1:0] ST_RESET      = 8'h00;
	localparam logic [DW-1:0] EN_RESET      = 8'h00;
	localparam logic [NCH-1:0] CTRL_RESET   = 4'hf;

	// consecutive errored cells that make an excessive run
	localparam logic [1:0] EXSEQ_LIMIT = 2'h3;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// [rtl/las_top.sv]
// las_top: per-channel sticky alarm status, shadow copies, alarm enables, AHB-Lite slave.
// assumes fault inputs are one-cycle pulses synchronous to mclk_i, one bus master.
//
// What this block does
// - set start-of-cell-missing flag when a cell is expected without start indication in cell mode
// - set transmit underflow flag, bit 6, on transmit FIFO underrun in cell mode
// - set transmit overflow flag, bit 7, on transmit FIFO overrun in cell mode
// - raise backpressure toward the fabric one cycle after the transmit FIFO reports full
// - set frame loss flag, bit 1, on out-of-frame in either mode
// - set repeated order fault flag, bit 2, after three consecutive sequence-errored cells in cell mode
// - set order fault flag, bit 3, on any received cell with sequence error in cell mode
// - set cell parity fault flag, bit 4, on cell-mode parity error
// - set section parity fault flag, bit 5, on section parity mismatch, either mode
// - set receive overflow flag, bit 6, on receive FIFO overrun in cell mode
// - set far end defect flag, bit 7, on remote defect indication
// - a set flag raises the alarm only while its enable bit is set
// - shadow status bits mirror every flag but never raise an alarm
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ns

module las_top
(
	input  wire logic                   mclk_i,            // 100 MHz clock
	input  wire logic                   rst_n_i,           // async reset, active low
	input  wire logic                   hsel_i,            // slave select
	input  wire logic [31:0]            haddr_i,           // byte address
	input  wire logic [1:0]             htrans_i,          // transfer type
	input  wire logic                   hwrite_i,          // write when high
	input  wire logic [2:0]             hsize_i,           // transfer size
	input  wire logic [31:0]            hwdata_i,          // write data
	input  wire logic                   hready_i,          // bus ready
	output logic      [31:0]            hrdata_o,          // read data
	output logic                        hreadyout_o,       // slave ready
	output logic                        hresp_o,           // response, always okay
	input  wire logic [las_pkg::NCH-1:0] tx_cell_expect_i,  // framer wants a new cell
	input  wire logic [las_pkg::NCH-1:0] tx_soc_i,          // start of cell seen
	input  wire logic [las_pkg::NCH-1:0] tx_fifo_wr_i,      // transmit fifo write
	input  wire logic [las_pkg::NCH-1:0] tx_fifo_full_i,    // transmit fifo full
	input  wire logic [las_pkg::NCH-1:0] tx_fifo_rd_i,      // transmit fifo read
	input  wire logic [las_pkg::NCH-1:0] tx_fifo_empty_i,   // transmit fifo empty
	input  wire logic [las_pkg::NCH-1:0] rx_oof_i,          // out of frame detected
	input  wire logic [las_pkg::NCH-1:0] rx_cell_i,         // received cell checked
	input  wire logic [las_pkg::NCH-1:0] rx_seq_err_i,      // that cell had seq error
	input  wire logic [las_pkg::NCH-1:0] rx_bip_err_i,      // cell parity error
	input  wire logic [las_pkg::NCH-1:0] rx_b1_err_i,       // section parity error
	input  wire logic [las_pkg::NCH-1:0] rx_fifo_ovr_i,     // receive fifo overrun
	input  wire logic [las_pkg::NCH-1:0] rx_rdi_i,          // remote defect seen
	output logic      [las_pkg::NCH-1:0] tx_backpressure_o, // stop feeding cells
	output logic      [las_pkg::NCH-1:0] alarm_o,           // per-channel alarm
	output logic                        irq_o              // any channel alarm
);

	localparam int NCH = las_pkg::NCH;
	localparam int DW  = las_pkg::DW;
	localparam int IW  = las_pkg::IDX_W;

	// bus state
	logic          wr_pend;
	logic [IW-1:0] wr_idx;
	logic [31:0]   next_rdata;

	// control: cell mode per channel
	logic [NCH-1:0] cell_mode;

	// per-channel registers
	logic [NCH-1:0][DW-1:0] tx_st;
	logic [NCH-1:0][DW-1:0] rx_st;
	logic [NCH-1:0][DW-1:0] tx_en;
	logic [NCH-1:0][DW-1:0] rx_en;
	logic [NCH-1:0][1:0]    seq_run;

	logic [NCH-1:0][DW-1:0] next_tx_st;
	logic [NCH-1:0][DW-1:0] next_rx_st;
	logic [NCH-1:0][DW-1:0] tx_set;
	logic [NCH-1:0][DW-1:0] rx_set;
	logic [NCH-1:0][DW-1:0] tx_clr;
	logic [NCH-1:0][DW-1:0] rx_clr;
	logic [NCH-1:0][1:0]    next_seq_run;
	logic [NCH-1:0]         next_alarm;

	// address phase decode
	wire           addr_take = hsel_i & hready_i & (htrans_i == las_pkg::HTRANS_NONSEQ);
	wire           rd_take   = addr_take & ~hwrite_i;
	wire           wr_take   = addr_take & hwrite_i;
	wire [IW-1:0]  rd_idx    = haddr_i[IW+1:2];
	wire [DW-1:0]  wdat      = hwdata_i[DW-1:0];
	wire           ctrl_we   = wr_pend & (wr_idx == las_pkg::CTRL_IDX);

	// zero wait states, so only the data phase write is held over
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_pend <= 1'h0;
			wr_idx  <= '0;
		end
		else
		begin
			wr_pend <= wr_take;
			wr_idx  <= haddr_i[IW+1:2];
		end
	end

	// read data is captured in the address phase so hrdata comes from a flop
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (rd_idx == las_pkg::CTRL_IDX)
		begin
			next_rdata = {28'h000_0000, cell_mode};
		end
		for (int c = 0; c < NCH; c++)
		begin
			// shadow reads the same state but never feeds the alarm path
			if (rd_idx == las_pkg::TX_ST_IDX[c] || rd_idx == las_pkg::TX_SH_IDX[c])
			begin
				next_rdata = {24'h00_0000, tx_st[c]};
			end
			if (rd_idx == las_pkg::RX_ST_IDX[c] || rd_idx == las_pkg::RX_SH_IDX[c])
			begin
				next_rdata = {24'h00_0000, rx_st[c]};
			end
			if (rd_idx == las_pkg::TX_EN_IDX[c])
			begin
				next_rdata = {24'h00_0000, tx_en[c]};
			end
			if (rd_idx == las_pkg::RX_EN_IDX[c])
			begin
				next_rdata = {24'h00_0000, rx_en[c]};
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hrdata_o    <= 32'h0000_0000;
			hreadyout_o <= 1'h1;
			hresp_o     <= las_pkg::HRESP_OKAY;
		end
		else
		begin
			if (rd_take)
			begin
				hrdata_o <= next_rdata;
			end
			hreadyout_o <= 1'h1;
			hresp_o     <= las_pkg::HRESP_OKAY;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cell_mode <= las_pkg::CTRL_RESET;
		end
		else if (ctrl_we)
		begin
			cell_mode <= hwdata_i[NCH-1:0];
		end
	end

	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		wire cm = cell_mode[c];
		wire ev_soc  = cm & tx_cell_expect_i[c] & ~tx_soc_i[c];
		wire ev_urun = cm & tx_fifo_rd_i[c] & tx_fifo_empty_i[c];
		wire ev_orun = cm & tx_fifo_wr_i[c] & tx_fifo_full_i[c];
		wire cell_chk = cm & rx_cell_i[c];
		wire ev_seq   = cell_chk & rx_seq_err_i[c];
		// run count reaching the limit includes the current errored cell
		wire ev_exseq = ev_seq & (seq_run[c] >= (las_pkg::EXSEQ_LIMIT - 2'h1));
		wire tx_st_we = wr_pend & (wr_idx == las_pkg::TX_ST_IDX[c]);
		wire rx_st_we = wr_pend & (wr_idx == las_pkg::RX_ST_IDX[c]);
		wire tx_en_we = wr_pend & (wr_idx == las_pkg::TX_EN_IDX[c]);
		wire rx_en_we = wr_pend & (wr_idx == las_pkg::RX_EN_IDX[c]);

		assign tx_set[c] = (DW'(ev_soc) << las_pkg::TX_SOC_BIT)
			| (DW'(ev_urun) << las_pkg::TX_URUN_BIT)
			| (DW'(ev_orun) << las_pkg::TX_ORUN_BIT);

		assign rx_set[c] = (DW'(rx_oof_i[c]) << las_pkg::RX_OOF_BIT)
			| (DW'(ev_exseq) << las_pkg::RX_EXSEQ_BIT)
			| (DW'(ev_seq) << las_pkg::RX_SEQ_BIT)
			| (DW'(cm & rx_bip_err_i[c]) << las_pkg::RX_BIP_BIT)
			| (DW'(rx_b1_err_i[c]) << las_pkg::RX_B1_BIT)
			| (DW'(cm & rx_fifo_ovr_i[c]) << las_pkg::RX_OVR_BIT)
			| (DW'(rx_rdi_i[c]) << las_pkg::RX_RDI_BIT);

		// write one to clear; a shadow write clears nothing
		assign tx_clr[c] = tx_st_we ? wdat : las_pkg::ST_RESET;
		assign rx_clr[c] = rx_st_we ? wdat : las_pkg::ST_RESET;

		// a new event wins over a clear in the same cycle
		assign next_tx_st[c] = ((tx_st[c] & ~tx_clr[c]) | tx_set[c])
			& las_pkg::TX_VALID_MASK;
		assign next_rx_st[c] = ((rx_st[c] & ~rx_clr[c]) | rx_set[c])
			& las_pkg::RX_VALID_MASK;

		assign next_seq_run[c] = !cell_chk ? seq_run[c]
			: !rx_seq_err_i[c] ? 2'h0
			: (seq_run[c] == las_pkg::EXSEQ_LIMIT) ? seq_run[c]
			: seq_run[c] + 2'h1;

		assign next_alarm[c] = (|(next_tx_st[c] & tx_en[c]))
			| (|(next_rx_st[c] & rx_en[c]));

		always_ff @(posedge mclk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
			begin
				tx_st[c]   <= las_pkg::ST_RESET;
				rx_st[c]   <= las_pkg::ST_RESET;
				seq_run[c] <= 2'h0;
			end
			else
			begin
				tx_st[c]   <= next_tx_st[c];
				rx_st[c]   <= next_rx_st[c];
				seq_run[c] <= next_seq_run[c];
			end
		end

		// enables hold only the implemented bit positions
		always_ff @(posedge mclk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
			begin
				tx_en[c] <= las_pkg::EN_RESET;
				rx_en[c] <= las_pkg::EN_RESET;
			end
			else
			begin
				if (tx_en_we)
				begin
					tx_en[c] <= wdat & las_pkg::TX_VALID_MASK;
				end
				if (rx_en_we)
				begin
					rx_en[c] <= wdat & las_pkg::RX_VALID_MASK;
				end
			end
		end
	end

	// backpressure follows fifo fullness one cycle late, so a write in the first full cycle can still overrun
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_backpressure_o <= '1;
			alarm_o           <= '0;
			irq_o             <= 1'h0;
		end
		else
		begin
			tx_backpressure_o <= tx_fifo_full_i;
			alarm_o           <= next_alarm;
			irq_o             <= |next_alarm;
		end
	end

endmodule

// [bench/las_link_model.sv]
// las_link_model: far-end link and receive checker stand-in, one event per request.
// assumes events are single-cycle pulses on the system clock.
`timescale 1ns/1ns
module las_link_model
(
	input  wire logic            mclk_i, // clock
	input  wire logic            go_i,   // fire one event
	input  wire logic [2:0]      kind_i, // lane to pulse
	input  wire logic [1:0]      ch_i,   // channel
	output logic      [6:0][3:0] ev_o    // oof,cell,seq,bip,b1,ovr,rdi
);
	initial
	begin
		ev_o = '0;
	end
	// a sequence error only counts with its cell, so it drags the cell lane
	always @(posedge mclk_i)
	begin
		ev_o <= '0;
		if (go_i)
		begin
			ev_o[kind_i][ch_i] <= 1'b1;
			if (kind_i == 3'h2)
				ev_o[1][ch_i] <= 1'b1;
		end
	end
endmodule

// [bench/las_chk_sva.sv]
// las_chk: port-level checks of the alarm status bank.
// assumes hready_i is tied to hreadyout_o and one bus master.
`timescale 1ns/1ns
module las_chk
(
	input wire logic        mclk_i,            // clock
	input wire logic        rst_n_i,           // reset
	input wire logic        hsel_i,            // select
	input wire logic [31:0] haddr_i,           // address
	input wire logic [1:0]  htrans_i,          // type
	input wire logic        hwrite_i,          // write
	input wire logic [31:0] hrdata_o,          // rdata
	input wire logic        hreadyout_o,       // ready
	input wire logic        hresp_o,           // resp
	input wire logic [3:0]  tx_fifo_full_i,    // full
	input wire logic [3:0]  tx_cell_expect_i,  // expect
	input wire logic [3:0]  tx_fifo_wr_i,      // fifo wr
	input wire logic [3:0]  tx_fifo_rd_i,      // fifo rd
	input wire logic [3:0]  rx_oof_i,          // oof
	input wire logic [3:0]  rx_cell_i,         // cell
	input wire logic [3:0]  rx_bip_err_i,      // bip
	input wire logic [3:0]  rx_b1_err_i,       // b1
	input wire logic [3:0]  rx_fifo_ovr_i,     // ovr
	input wire logic [3:0]  rx_rdi_i,          // rdi
	input wire logic [3:0]  tx_backpressure_o, // bp
	input wire logic [3:0]  alarm_o,           // alarm
	input wire logic        irq_o              // irq
);
	wire logic [19:0] ix = haddr_i[21:2];
	wire logic take = hsel_i && hreadyout_o && htrans_i == las_pkg::HTRANS_NONSEQ;
	wire logic st = ix[19:9] == 11'h184 && ix[7:5] == 3'h1 && ix[3:2] == 2'h2;
	// superset of causes: keeps the cause check sound without modelling status
	wire logic any_ev = |{tx_cell_expect_i, tx_fifo_wr_i, tx_fifo_rd_i, rx_oof_i, rx_cell_i,
		rx_bip_err_i, rx_b1_err_i, rx_fifo_ovr_i, rx_rdi_i};
	logic wr_q, rd_tx, rd_rx;
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			{wr_q, rd_tx, rd_rx} <= 3'h0;
		else
			{wr_q, rd_tx, rd_rx} <= {take && hwrite_i, take && !hwrite_i && st && !ix[0],
				take && !hwrite_i && st && ix[0]};
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	property p_bp; $past(rst_n_i) |-> tx_backpressure_o == $past(tx_fifo_full_i); endproperty
	a_bp: assert property (p_bp) else $error("backpressure is not full delayed");
	property p_irq; irq_o == |alarm_o; endproperty
	a_irq: assert property (p_irq) else $error("irq differs from alarm or");
	property p_cause; $rose(irq_o) |-> $past(any_ev) || $past(wr_q); endproperty
	a_cause: assert property (p_cause) else $error("irq rose without cause");
	property p_quiet; !any_ev && !wr_q |=> $stable(alarm_o); endproperty
	a_quiet: assert property (p_quiet) else $error("alarm moved on a read");
	property p_fall; $fell(irq_o) |-> $past(wr_q); endproperty
	a_fall: assert property (p_fall) else $error("irq fell without write");
	property p_txr; rd_tx |-> hrdata_o[4:0] == 5'h00 && hrdata_o[31:8] == 24'h0; endproperty
	a_txr: assert property (p_txr) else $error("tx reserved bits set");
	property p_rxr; rd_rx |-> !hrdata_o[0] && hrdata_o[31:8] == 24'h0; endproperty
	a_rxr: assert property (p_rxr) else $error("rx reserved bits set");
	property p_ok; hreadyout_o && hresp_o == las_pkg::HRESP_OKAY; endproperty
	a_ok: assert property (p_ok) else $error("bus not ready or not okay");
	c_irq: cover property ($rose(irq_o));
	c_rx: cover property (rd_rx && hrdata_o[2]);
	c_tx: cover property (rd_tx && hrdata_o[7]);
endmodule
bind las_top las_chk u_chk (.*);

// [bench/link_alarm_status_tb.sv]
// link_alarm_status_tb: directed scenarios over the bus and the fault inputs.
// assumes a zero-wait AHB-Lite slave and the link model on the receive events.
`timescale 1ns/1ns
module link_alarm_status_tb;
	logic mclk_i, rst_n_i, hsel_i, hwrite_i, go, hreadyout_o, hresp_o, irq_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, d;
	logic [1:0] htrans_i, ch;
	logic [2:0] kind;
	logic [3:0] t_exp, t_soc, t_wr, t_full, t_rd, t_emp, bp, alarm;
	logic [6:0][3:0] ev;
	int err_total, comparisons;
	las_top DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o), .tx_cell_expect_i(t_exp), .tx_soc_i(t_soc), .tx_fifo_wr_i(t_wr),
		.tx_fifo_full_i(t_full), .tx_fifo_rd_i(t_rd), .tx_fifo_empty_i(t_emp),
		.rx_oof_i(ev[0]), .rx_cell_i(ev[1]), .rx_seq_err_i(ev[2]), .rx_bip_err_i(ev[3]),
		.rx_b1_err_i(ev[4]), .rx_fifo_ovr_i(ev[5]), .rx_rdi_i(ev[6]),
		.tx_backpressure_o(bp), .alarm_o(alarm), .irq_o(irq_o));
	las_link_model u_link (.mclk_i(mclk_i), .go_i(go), .kind_i(kind), .ch_i(ch), .ev_o(ev));
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("errors=%0d comparisons=%0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic rdy();
		int n;
		n = 0;
		@(posedge mclk_i);
		while (hreadyout_o !== 1'b1)
		begin
			n++;
			if (n > 50)
			begin
				err_total++;
				final_report();
			end
			@(posedge mclk_i);
		end
	endtask
	task automatic bus(input logic w, input logic [19:0] ix, input logic [7:0] wd);
		{hsel_i, htrans_i, haddr_i, hwrite_i} <= {1'b1, las_pkg::HTRANS_NONSEQ, 10'h0, ix, 2'h0, w};
		rdy();
		{hsel_i, htrans_i, hwdata_i} <= {1'b0, 2'h0, 24'h0, wd};
		rdy();
		d = hrdata_o;
	endtask
	task automatic rd(input logic [19:0] ix, input logic [7:0] e);
		bus(1'b0, ix, 8'h00);
		chk(d, {24'h0, e});
	endtask
	task automatic pulse(input logic [2:0] k, input logic [1:0] c);
		{go, kind, ch} <= {1'b1, k, c};
		@(posedge mclk_i);
		go <= 1'b0;
		repeat (3) @(posedge mclk_i);
	endtask
	task automatic txp(input logic [3:0] e, w, f, r, m);
		{t_exp, t_wr, t_full, t_rd, t_emp} <= {e, w, f, r, m};
		@(posedge mclk_i);
		#1;
		chk({28'h0, bp}, {28'h0, f});
		{t_exp, t_wr, t_full, t_rd, t_emp} <= 20'h0;
		repeat (2) @(posedge mclk_i);
	endtask
	task automatic t_rx();
		logic [2:0] ks [5] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6};
		int bs [5] = '{1, 4, 5, 6, 7};
		for (int i = 0; i < 5; i++)
		begin
			pulse(ks[i], 2'(i));
			rd(las_pkg::RX_ST_IDX[i % 4], 8'h01 << bs[i]);
			rd(las_pkg::RX_SH_IDX[i % 4], 8'h01 << bs[i]);
			bus(1'b1, las_pkg::RX_ST_IDX[i % 4], 8'hff);
			rd(las_pkg::RX_ST_IDX[i % 4], 8'h00);
		end
	endtask
	task automatic t_seq();
		pulse(3'h2, 2'h1);
		pulse(3'h2, 2'h1);
		pulse(3'h1, 2'h1);
		pulse(3'h2, 2'h1);
		rd(las_pkg::RX_ST_IDX[1], 8'h08);
		pulse(3'h2, 2'h1);
		pulse(3'h2, 2'h1);
		rd(las_pkg::RX_ST_IDX[1], 8'h0c);
	endtask
	task automatic t_tx();
		t_soc <= 4'h4;
		txp(4'h4, 4'h0, 4'h0, 4'h0, 4'h0);
		t_soc <= 4'h0;
		rd(las_pkg::TX_ST_IDX[2], 8'h00);
		txp(4'h4, 4'h0, 4'h0, 4'h0, 4'h0);
		rd(las_pkg::TX_ST_IDX[2], 8'h20);
		txp(4'h0, 4'h4, 4'h0, 4'h4, 4'h4);
		rd(las_pkg::TX_ST_IDX[2], 8'h60);
		txp(4'h0, 4'h4, 4'h4, 4'h4, 4'h0);
		rd(las_pkg::TX_SH_IDX[2], 8'he0);
	endtask
	task automatic t_alarm();
		bus(1'b1, las_pkg::RX_EN_IDX[3], 8'h80);
		pulse(3'h5, 2'h3);
		chk({27'h0, irq_o, alarm}, 32'h0);
		pulse(3'h6, 2'h3);
		chk({27'h0, irq_o, alarm}, 32'h18);
		bus(1'b1, las_pkg::RX_SH_IDX[3], 8'hff);
		rd(las_pkg::RX_SH_IDX[3], 8'hc0);
		bus(1'b1, las_pkg::RX_EN_IDX[3], 8'h40);
		bus(1'b1, las_pkg::RX_ST_IDX[3], 8'h40);
		@(posedge mclk_i);
		chk({27'h0, irq_o, alarm}, 32'h0);
	endtask
	initial
	begin
		{rst_n_i, hsel_i, hwrite_i, go, htrans_i, ch, kind, haddr_i, hwdata_i} = '0;
		{t_exp, t_soc, t_wr, t_full, t_rd, t_emp, err_total, comparisons} = '0;
		repeat (20) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		for (int k = 0; k < 4; k++)
			rd(las_pkg::TX_ST_IDX[k] + 20'(k & 1), las_pkg::ST_RESET);
		rd(las_pkg::CTRL_IDX, 8'h0f);
		bus(1'b1, 20'h00100, 8'hff);
		rd(20'h00100, 8'h00);
		t_rx();
		t_seq();
		t_tx();
		t_alarm();
		bus(1'b1, las_pkg::CTRL_IDX, 8'h0e);
		pulse(3'h3, 2'h0);
		pulse(3'h4, 2'h0);
		rd(las_pkg::RX_ST_IDX[0], 8'h20);
		final_report();
	end
endmodule
